/* tb/cgs_regs_asserts.sv */
`timescale 1ns/1ps
// ==========
// checker on the top-level ports
module cgs_regs_chk (
  input wire       aclk,
  input wire       aresetn,
  input wire [7:0] agc_gain_in,
  input wire       ast_sign_in,
  input wire       dst_sign_in,
  input wire       agc_enable_bit,
  input wire       agc_attack_tick,
  input wire       agc_decay_tick,
  input wire [7:0] adc_gain_field,
  input wire       left_dac_mute,
  input wire [6:0] left_dac_volume,
  input wire       right_dac_mute,
  input wire [6:0] right_dac_volume,
  input wire       analog_sidetone_mute,
  input wire [6:0] analog_sidetone_gain,
  input wire       digital_sidetone_mute,
  input wire [5:0] digital_sidetone_gain
);
  // ==========
  // cycles since each sign pin last moved; sync plus apply is well under 6
  reg       ast_s_q, dst_s_q;
  reg [3:0] ast_age_q, dst_age_q;
  always @(posedge aclk) begin
    ast_s_q <= ast_sign_in;
    dst_s_q <= dst_sign_in;
    if (!aresetn || ast_sign_in != ast_s_q) ast_age_q <= 4'h0;
    else if (ast_age_q != 4'hf) ast_age_q <= ast_age_q + 4'h1;
    if (!aresetn || dst_sign_in != dst_s_q) dst_age_q <= 4'h0;
    else if (dst_age_q != 4'hf) dst_age_q <= dst_age_q + 4'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========
  // assertions
  a_agc_gain_path: assert property (
    agc_enable_bit |=> adc_gain_field == $past(agc_gain_in)) else $error("adc gain not from agc loop");
  a_ticks_gated: assert property (
    !agc_enable_bit [*2] |-> !agc_attack_tick && !agc_decay_tick) else $error("agc tick while off");
  a_attack_pulse: assert property (
    agc_attack_tick |=> !agc_attack_tick) else $error("attack tick too long");
  a_decay_pulse: assert property (
    agc_decay_tick |=> !agc_decay_tick) else $error("decay tick too long");
  a_ast_clamp: assert property (
    analog_sidetone_gain <= 7'h5d) else $error("analog gain above clamp");
  a_dst_floor: assert property (
    digital_sidetone_gain[5] |-> digital_sidetone_gain == 6'h20) else $error("digital floor wrong");
  a_ast_zero_cross: assert property (
    $changed(analog_sidetone_gain) |-> ast_age_q < 4'h6) else $error("analog gain moved off crossing");
  a_dst_zero_cross: assert property (
    $changed(digital_sidetone_gain) |-> dst_age_q < 4'h6) else $error("digital gain moved off crossing");
  a_reset_state: assert property (
    $rose(aresetn) |-> left_dac_mute && right_dac_mute && analog_sidetone_mute && digital_sidetone_mute
      && left_dac_volume == 7'h7f && right_dac_volume == 7'h7f && analog_sidetone_gain == 7'h45
      && digital_sidetone_gain == 6'h00 && !agc_enable_bit) else $error("bad state after reset");

  c_attack: cover property (agc_attack_tick);
  c_ast_move: cover property ($changed(analog_sidetone_gain));
  c_dst_move: cover property ($changed(digital_sidetone_gain));
endmodule // cgs_regs_chk

bind cgs_regs_top cgs_regs_chk u_chk (
  .aclk, .aresetn, .agc_gain_in, .ast_sign_in, .dst_sign_in, .agc_enable_bit, .agc_attack_tick,
  .agc_decay_tick, .adc_gain_field, .left_dac_mute, .left_dac_volume, .right_dac_mute,
  .right_dac_volume, .analog_sidetone_mute, .analog_sidetone_gain, .digital_sidetone_mute,
  .digital_sidetone_gain
);

/* tb/cgs_regs_top_tb.sv */
`timescale 1ns/1ps
module cgs_regs_top_tb;
  // short periods keep the run small
  localparam [31:0] ATK = {8'd20, 8'd16, 8'd11, 8'd8};
  localparam [31:0] DEC = {8'd70, 8'd60, 8'd50, 8'd40};
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, agc_gain_in = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg         ast_sign_in = 1'b0, dst_sign_in = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        agc_enable_bit, agc_attack_tick, agc_decay_tick;
  wire [3:0]  agc_time_constant;
  wire [7:0]  adc_gain_field;
  wire        left_dac_mute, right_dac_mute, analog_sidetone_mute, digital_sidetone_mute;
  wire [6:0]  left_dac_volume, right_dac_volume, analog_sidetone_gain;
  wire [5:0]  digital_sidetone_gain;
  wire [15:0] dac = {left_dac_mute, left_dac_volume, right_dac_mute, right_dac_volume};
  wire [14:0] st  = {analog_sidetone_mute, analog_sidetone_gain, digital_sidetone_mute, digital_sidetone_gain};
  wire [12:0] adc = {agc_enable_bit, agc_time_constant, adc_gain_field};
  integer     err_count = 0, n_tests = 0, cyc = 0, i;

  cgs_regs_top #(
    .ATK0_CYC(ATK[7:0]), .ATK1_CYC(ATK[15:8]), .ATK2_CYC(ATK[23:16]), .ATK3_CYC(ATK[31:24]),
    .DEC0_CYC(DEC[7:0]), .DEC1_CYC(DEC[15:8]), .DEC2_CYC(DEC[23:16]), .DEC3_CYC(DEC[31:24])
  ) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .agc_gain_in, .ast_sign_in,
    .dst_sign_in, .agc_enable_bit, .agc_time_constant, .agc_attack_tick, .agc_decay_tick,
    .adc_gain_field, .left_dac_mute, .left_dac_volume, .right_dac_mute, .right_dac_volume,
    .analog_sidetone_mute, .analog_sidetone_gain, .digital_sidetone_mute, .digital_sidetone_gain
  );

  always #20 aclk = ~aclk;

  // ==========
  // tasks
  task finish_test;
    begin
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task settle(input integer n);
    begin
      repeat (n) @(posedge aclk);
      @(negedge aclk);
    end
  endtask

  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
    end
  endtask

  task rd(input [7:0] a, input [31:0] exp, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, exp);
      chk(s_axi_rresp, er);
    end
  endtask

  // interval between the 2nd and 3rd tick, after any old period has run out
  task per(input sel, input [31:0] exp);
    integer n, k;
    begin
      n = 0;
      for (k = 0; k < 3; k = k + 1) begin
        n = 0;
        @(posedge aclk);
        while ((sel ? agc_decay_tick : agc_attack_tick) !== 1'b1 && n < 200) begin
          n = n + 1;
          @(posedge aclk);
        end
      end
      chk(n + 1, exp);
    end
  endtask

  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      $display("FAIL %0t timeout", $time);
      finish_test;
    end
  end

  // ==========
  // sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(dac, 32'hffff);
    chk(st, 32'h62c0);
    chk(adc, 32'h0080);
    rd(8'h04, 32'h8000, 2'b00);
    rd(8'h08, 32'hffff, 2'b00);
    rd(8'h0c, 32'hc581, 2'b00);
    // unmapped index
    wr(8'h10, 32'hffff, 4'hf, 2'b10);
    rd(8'h10, 32'h0, 2'b10);
    // dac fields, then an upper-byte-only write
    wr(8'h08, 32'h1234, 4'hf, 2'b00);
    settle(0);
    chk(dac, 32'h1234);
    wr(8'h08, 32'hffff, 4'h2, 2'b00);
    rd(8'h08, 32'hff34, 2'b00);
    // sidetone: gain above clamp, digital floor, flag bit written as 1
    wr(8'h0c, 32'h6043, 4'hf, 2'b00);
    settle(2);
    chk(st, 32'h2280);
    rd(8'h0c, 32'h6042, 2'b00);
    @(posedge aclk);
    ast_sign_in <= 1'b1;
    settle(8);
    chk(st, 32'h2e80);
    rd(8'h0c, 32'h6043, 2'b00);
    @(posedge aclk);
    dst_sign_in <= 1'b1;
    settle(8);
    chk(st, 32'h2ea0);
    wr(8'h0c, 32'h4504, 4'hf, 2'b00);
    @(posedge aclk);
    ast_sign_in <= 1'b0;
    dst_sign_in <= 1'b0;
    settle(8);
    chk(st, 32'h2282);
    rd(8'h0c, 32'h4505, 2'b00);
    // agc off, then every time constant with agc on
    @(posedge aclk);
    agc_gain_in <= 8'ha5;
    wr(8'h04, 32'h3ae0, 4'hf, 2'b00);
    settle(1);
    chk(adc, 32'h003a);
    rd(8'h04, 32'h3ae0, 2'b00);
    for (i = 0; i < 16; i = i + 1) begin
      wr(8'h04, 32'h3a01 | (i << 1), 4'hf, 2'b00);
      settle(1);
      chk(adc, 32'h10a5 | (i << 8));
      rd(8'h04, 32'ha501 | (i << 1), 2'b00);
      per(1'b0, ATK[(i % 4) * 8 +: 8]);
      per(1'b1, DEC[(i / 4) * 8 +: 8]);
    end
    wr(8'h04, 32'h5500, 4'hf, 2'b00);
    settle(1);
    chk(adc, 32'h0055);
    finish_test;
  end
endmodule // cgs_regs_top_tb

/* verilog/cgs_agc_timer.v */
`timescale 1ns/1ps
// =====================================================
// periodic tick from the system clock, so the period
// stays fixed in absolute time whatever the sample rate
module cgs_agc_timer (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        run,
  input  wire [23:0] period,
  output reg         tick_q
);

  reg [23:0] cnt_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= 24'h000000;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q  <= 24'h000000;
      tick_q <= 1'b0;
    end else if (cnt_q >= period - 24'h000001) begin
      cnt_q  <= 24'h000000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

endmodule // cgs_agc_timer

/* verilog/cgs_defs.vh */
`ifndef CGS_DEFS_VH
`define CGS_DEFS_VH

// =====================================================
// register indices (byte address = index * 4)
`define CGS_IDX_ADC      8'h01
`define CGS_IDX_DAC      8'h02
`define CGS_IDX_ST       8'h03

// =====================================================
// reset values
`define CGS_RST_ADC      16'h8000
`define CGS_RST_DAC      16'hffff
`define CGS_RST_ST       16'hc580
`define CGS_RST_AST_GAIN 7'h45
`define CGS_RST_DST_GAIN 6'h00

// =====================================================
// field positions
`define CGS_AGC_EN_BIT   0
`define CGS_TC_LO        1
`define CGS_TC_HI        4
`define CGS_ST_FLAG_BIT  0

// =====================================================
// gain code limits
`define CGS_AST_MAX      7'h5d
`define CGS_DST_FLOOR    6'h20

// =====================================================
// timing: times in ms, clock in kHz
// sized to the 24-bit period counters; 500 ms at 25 MHz still fits
`define CGS_CLK_KHZ      24'h0061a8
`define CGS_ATK0_MS      24'h000008
`define CGS_ATK1_MS      24'h00000b
`define CGS_ATK2_MS      24'h000010
`define CGS_ATK3_MS      24'h000014
`define CGS_DEC0_MS      24'h000064
`define CGS_DEC1_MS      24'h0000c8
`define CGS_DEC2_MS      24'h000190
`define CGS_DEC3_MS      24'h0001f4

// =====================================================
// bus responses
`define CGS_RESP_OKAY    2'b00
`define CGS_RESP_SLVERR  2'b10

`endif

/* verilog/cgs_regs_top.v */
`timescale 1ns/1ps
`include "cgs_defs.vh"

// Operation
// - time constant low bits pick attack 8/11/16/20 ms, high bits decay 100-500 ms.
// - attack and decay periods are fixed absolute times, counted on the system clock.
// - agc enable 0 uses programmed pga gain, 1 uses the agc loop; resets 0.
// - left dac mute 1 silences left channel, resets to 1.
// - left dac volume, 0.5 dB attenuation steps, resets to all ones.
// - right dac mute 1 silences right channel, resets to 1.
// - right dac volume, 0.5 dB attenuation steps, resets to all ones.
// - analog sidetone mute 1 mutes the path, resets to 1.
// - analog sidetone gain from -34.5 dB, reset 0 dB, codes from 0x5d give 12 dB.
// - digital sidetone mute 1 mutes the path, resets to 1.
// - digital sidetone gain 1.5 dB steps, top bit set gives -48 dB, resets 0.
// - new digital sidetone gain applied only at a zero crossing.
// - analog sidetone gain changes only at zero crossings.
// - analog settled flag reads 1 when applied equals the clamped setting, else 0; resets 0.
// - with agc enabled, upper adc gain bits read back the agc applied gain.
module cgs_regs_top #(
  parameter        AW       = 8,
  parameter [23:0] ATK0_CYC = `CGS_ATK0_MS * `CGS_CLK_KHZ,
  parameter [23:0] ATK1_CYC = `CGS_ATK1_MS * `CGS_CLK_KHZ,
  parameter [23:0] ATK2_CYC = `CGS_ATK2_MS * `CGS_CLK_KHZ,
  parameter [23:0] ATK3_CYC = `CGS_ATK3_MS * `CGS_CLK_KHZ,
  parameter [23:0] DEC0_CYC = `CGS_DEC0_MS * `CGS_CLK_KHZ,
  parameter [23:0] DEC1_CYC = `CGS_DEC1_MS * `CGS_CLK_KHZ,
  parameter [23:0] DEC2_CYC = `CGS_DEC2_MS * `CGS_CLK_KHZ,
  parameter [23:0] DEC3_CYC = `CGS_DEC3_MS * `CGS_CLK_KHZ
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire [2:0]    s_axi_awprot,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output wire [1:0]    s_axi_bresp,
  output wire          s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire [2:0]    s_axi_arprot,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output wire [31:0]   s_axi_rdata,
  output wire [1:0]    s_axi_rresp,
  output wire          s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire [7:0]    agc_gain_in,
  input  wire          ast_sign_in,
  input  wire          dst_sign_in,
  output wire          agc_enable_bit,
  output wire [3:0]    agc_time_constant,
  output wire          agc_attack_tick,
  output wire          agc_decay_tick,
  output wire [7:0]    adc_gain_field,
  output wire          left_dac_mute,
  output wire [6:0]    left_dac_volume,
  output wire          right_dac_mute,
  output wire [6:0]    right_dac_volume,
  output wire          analog_sidetone_mute,
  output wire [6:0]    analog_sidetone_gain,
  output wire          digital_sidetone_mute,
  output wire [5:0]    digital_sidetone_gain
);

  // =====================================================
  // register storage
  reg  [15:0] adc_q;
  reg  [15:0] dac_q;
  reg  [15:1] st_q;

  // full-width copies so the reset loads can be sliced on purpose
  localparam [15:0] ST_RST_FULL  = `CGS_RST_ST;
  localparam [15:0] ADC_RST_FULL = `CGS_RST_ADC;

  // =====================================================
  // bus slave state
  reg          awready_q;
  reg          wready_q;
  reg          aw_full_q;
  reg          w_full_q;
  reg [AW-1:0] awaddr_q;
  reg [31:0]   wdata_q;
  reg [3:0]    wstrb_q;
  reg          bvalid_q;
  reg [1:0]    bresp_q;
  reg          arready_q;
  reg          rvalid_q;
  reg [31:0]   rdata_q;
  reg [1:0]    rresp_q;

  wire         do_wr = aw_full_q & w_full_q & ~bvalid_q;
  wire [AW-3:0] wr_idx = awaddr_q[AW-1:2];
  wire [AW-3:0] rd_idx = s_axi_araddr[AW-1:2];

  // =====================================================
  // pin synchronisers and zero-crossing detect
  reg [2:0] ast_sync_q;
  reg [2:0] dst_sync_q;
  wire      ast_zc = ast_sync_q[2] ^ ast_sync_q[1];
  wire      dst_zc = dst_sync_q[2] ^ dst_sync_q[1];

  always @(posedge aclk) begin
    if (!aresetn) begin
      ast_sync_q <= 3'h0;
      dst_sync_q <= 3'h0;
    end else begin
      ast_sync_q <= {ast_sync_q[1:0], ast_sign_in};
      dst_sync_q <= {dst_sync_q[1:0], dst_sign_in};
    end
  end

  // =====================================================
  // write address / data capture, either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b0;
      awaddr_q  <= {AW{1'b0}};
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_full_q <= 1'b0;
    end else if (!aw_full_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_wr) begin
      w_full_q <= 1'b0;
    end else if (!w_full_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // =====================================================
  // write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `CGS_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      if (wr_idx == `CGS_IDX_ADC || wr_idx == `CGS_IDX_DAC || wr_idx == `CGS_IDX_ST) begin
        bresp_q <= `CGS_RESP_OKAY;
      end else begin
        bresp_q <= `CGS_RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // =====================================================
  // register writes, byte lanes 0 and 1 only
  function [15:0] merge;
    input [15:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    begin
      merge[7:0]  = strb[0] ? nw[7:0]  : old[7:0];
      merge[15:8] = strb[1] ? nw[15:8] : old[15:8];
    end
  endfunction

  wire [15:0] st_full   = {st_q, 1'b0};
  wire [15:0] st_merged = merge(st_full, wdata_q, wstrb_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      adc_q <= `CGS_RST_ADC;
      dac_q <= `CGS_RST_DAC;
      st_q  <= ST_RST_FULL[15:1];
    end else if (do_wr) begin
      if (wr_idx == `CGS_IDX_ADC) begin
        adc_q <= merge(adc_q, wdata_q, wstrb_q);
      end
      if (wr_idx == `CGS_IDX_DAC) begin
        dac_q <= merge(dac_q, wdata_q, wstrb_q);
      end
      if (wr_idx == `CGS_IDX_ST) begin
        st_q <= st_merged[15:1];
      end
    end
  end

  // =====================================================
  // read channel, answer one cycle after address taken
  wire        agc_on = adc_q[`CGS_AGC_EN_BIT];
  wire        ast_settled;
  wire [15:0] adc_rd = agc_on ? {agc_gain_in, adc_q[7:0]} : adc_q;
  reg  [31:0] rd_mux;
  reg  [1:0]  rd_resp;

  always @* begin
    rd_mux  = 32'h00000000;
    rd_resp = `CGS_RESP_OKAY;
    if (rd_idx == `CGS_IDX_ADC) begin
      rd_mux = {16'h0000, adc_rd};
    end else if (rd_idx == `CGS_IDX_DAC) begin
      rd_mux = {16'h0000, dac_q};
    end else if (rd_idx == `CGS_IDX_ST) begin
      rd_mux = {16'h0000, st_q, ast_settled};
    end else begin
      rd_resp = `CGS_RESP_SLVERR;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `CGS_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= rd_resp;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // =====================================================
  // agc attack / decay period select
  reg  [23:0] atk_per_q;
  reg  [23:0] dec_per_q;
  wire [3:0]  tc = adc_q[`CGS_TC_HI:`CGS_TC_LO];

  always @(posedge aclk) begin
    if (!aresetn) begin
      atk_per_q <= ATK0_CYC;
      dec_per_q <= DEC0_CYC;
    end else begin
      case (tc[1:0])
        2'h0:    atk_per_q <= ATK0_CYC;
        2'h1:    atk_per_q <= ATK1_CYC;
        2'h2:    atk_per_q <= ATK2_CYC;
        default: atk_per_q <= ATK3_CYC;
      endcase
      case (tc[3:2])
        2'h0:    dec_per_q <= DEC0_CYC;
        2'h1:    dec_per_q <= DEC1_CYC;
        2'h2:    dec_per_q <= DEC2_CYC;
        default: dec_per_q <= DEC3_CYC;
      endcase
    end
  end

  // counted on aclk, not on the sample clock
  cgs_agc_timer u_atk (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (agc_on),
    .period  (atk_per_q),
    .tick_q  (agc_attack_tick)
  );

  cgs_agc_timer u_dec (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (agc_on),
    .period  (dec_per_q),
    .tick_q  (agc_decay_tick)
  );

  // =====================================================
  // sidetone gains through zero-cross followers
  wire [6:0] ast_prog = st_q[14:8];
  wire [6:0] ast_tgt  = (ast_prog >= `CGS_AST_MAX) ? `CGS_AST_MAX : ast_prog;
  wire [5:0] dst_app;

  cgs_zc_gain #(
    .W   (7),
    .RST (`CGS_RST_AST_GAIN)
  ) u_ast (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .target    (ast_tgt),
    .zc        (ast_zc),
    .applied_q (analog_sidetone_gain),
    .settled_q (ast_settled)
  );

  cgs_zc_gain #(
    .W   (6),
    .RST (`CGS_RST_DST_GAIN)
  ) u_dst (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .target    (st_q[6:1]),
    .zc        (dst_zc),
    .applied_q (dst_app),
    .settled_q ()
  );

  // =====================================================
  // registered controls to the datapath
  reg       dst_mute_q;
  reg [5:0] dst_gain_q;
  reg [7:0] pga_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      dst_mute_q <= 1'b1;
      dst_gain_q <= `CGS_RST_DST_GAIN;
      pga_q      <= ADC_RST_FULL[15:8];
    end else begin
      dst_mute_q <= st_q[7];
      // any code with the top bit set floors at -48 dB
      dst_gain_q <= dst_app[5] ? `CGS_DST_FLOOR : dst_app;
      pga_q      <= agc_on ? agc_gain_in : adc_q[15:8];
    end
  end

  assign agc_enable_bit        = adc_q[`CGS_AGC_EN_BIT];
  assign agc_time_constant     = tc;
  assign adc_gain_field        = pga_q;
  assign left_dac_mute         = dac_q[15];
  assign left_dac_volume       = dac_q[14:8];
  assign right_dac_mute        = dac_q[7];
  assign right_dac_volume      = dac_q[6:0];
  assign analog_sidetone_mute  = st_q[15];
  assign digital_sidetone_mute = dst_mute_q;
  assign digital_sidetone_gain = dst_gain_q;

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule // cgs_regs_top

/* verilog/cgs_zc_gain.v */
`timescale 1ns/1ps
// =====================================================
// gain follower that moves only at zero crossings
module cgs_zc_gain #(
  parameter         W   = 7,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] target,
  input  wire         zc,
  output reg  [W-1:0] applied_q,
  output reg          settled_q
);

  always @(posedge aclk) begin
    if (!aresetn) begin
      applied_q <= RST;
      settled_q <= 1'b0;
    end else begin
      if (zc) begin
        applied_q <= target;
      end
      // flag lags the applied value by one cycle
      settled_q <= (applied_q == target);
    end
  end

endmodule // cgs_zc_gain
